// ==== core/drt_top.sv ====
// dual 8-bit reload timer/counter with clock selection and chaining
// assumes cpu-side strobes and data come from the core clock domain;
// the external count pin is asynchronous
`default_nettype none

module drt_top
   import drt_pkg::*;
#(
   parameter int B_SLOW_DIV = B_SLOW_DEF
)
(
   input  wire logic               CORE_CLK_I,
   input  wire logic               RESET_N_I,
   input  wire logic               EXTERNAL_COUNT_INPUT_I,
   input  wire logic               CTRL_WR_I,
   input  wire logic [A_SEL_W-1:0] TIMER_A_CLK_SEL_I,
   input  wire logic [B_SEL_W-1:0] TIMER_B_CLK_SEL_I,
   input  wire logic               TIMER_B_COUNTER_MODE_I,
   input  wire logic               TIMER_A_IRQ_EN_I,
   input  wire logic               TIMER_B_IRQ_EN_I,
   input  wire logic               TIMER_A_PRESET_WR_I,
   input  wire logic [CNT_W-1:0]   TIMER_A_PRESET_I,
   input  wire logic               TIMER_B_PRESET_WR_I,
   input  wire logic [CNT_W-1:0]   TIMER_B_PRESET_I,
   input  wire logic               TIMER_B_COUNT_WR_I,
   input  wire logic [CNT_W-1:0]   TIMER_B_COUNT_I,
   output var  logic [CNT_W-1:0]   TIMER_A_COUNT_O,
   output var  logic [CNT_W-1:0]   TIMER_B_COUNT_O,
   output var  logic               TIMER_A_IRQ_O,
   output var  logic               TIMER_B_IRQ_O
);

   // true when every bit of the mask is set in the prescaler
   function automatic logic pre_hit(input logic [PRE_A_W-1:0] val,
                                    input logic [PRE_A_W-1:0] mask);
      pre_hit = (val & mask) == mask;
   endfunction

   localparam logic [PRE_B_W-1:0] PRE_B_LAST = PRE_B_W'(B_SLOW_DIV - 1);

   logic [A_SEL_W-1:0] a_sel_ff;
   logic [B_SEL_W-1:0] b_sel_ff;
   logic               b_cnt_mode_ff;
   logic               a_irq_en_ff;
   logic               b_irq_en_ff;
   logic [PRE_A_W-1:0] pre_a_ff;
   logic [PRE_B_W-1:0] pre_b_ff;
   logic               ext_meta_ff;
   logic               ext_sync_ff;
   logic               ext_prev_ff;
   logic               a_irq_ff;
   logic               b_irq_ff;
   logic               a_tick;
   logic               b_tick;
   logic               b_slow_tick;
   logic               ext_edge;
   logic               a_ovf;
   logic               b_ovf;
   logic               b_clear;
   logic [PRE_A_W-1:0] a_gap_ff;
   logic               a_run_ff;

   // control settings, captured on a cpu strobe
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         a_sel_ff      <= A_SEL_RST;                   // [R09]
         b_sel_ff      <= B_SEL_RST;                   // [R09]
         b_cnt_mode_ff <= 1'b0;                        // [R09]
         a_irq_en_ff   <= 1'b0;                        // [R09]
         b_irq_en_ff   <= 1'b0;                        // [R09]
      end
      else if (CTRL_WR_I)
      begin
         a_sel_ff      <= TIMER_A_CLK_SEL_I;
         b_sel_ff      <= TIMER_B_CLK_SEL_I;
         b_cnt_mode_ff <= TIMER_B_COUNTER_MODE_I;      // [R01]
         a_irq_en_ff   <= TIMER_A_IRQ_EN_I;
         b_irq_en_ff   <= TIMER_B_IRQ_EN_I;
      end
   end

   // free-running prescaler for the first unit
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         pre_a_ff <= PRE_A_RST;
      else
         pre_a_ff <= pre_a_ff + PRE_A_STEP;
   end

   // slow prescaler for the second unit, wraps at the divide figure
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         pre_b_ff <= PRE_B_RST;
      else if (pre_b_ff == PRE_B_LAST)
         pre_b_ff <= PRE_B_RST;
      else
         pre_b_ff <= pre_b_ff + PRE_B_STEP;
   end

   assign b_slow_tick = pre_b_ff == PRE_B_LAST;

   // pin synchroniser then edge detect; costs two cycles of latency
   // and limits pin rate to below half the core clock
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
      end
      else
      begin
         ext_meta_ff <= EXTERNAL_COUNT_INPUT_I;
         ext_sync_ff <= ext_meta_ff;
         ext_prev_ff <= ext_sync_ff;
      end
   end

   assign ext_edge = ext_sync_ff && !ext_prev_ff;

   // first unit clock source
   always_comb
   begin
      case (a_sel_ff)
         A_SEL_CPU:   a_tick = 1'b1;                   // [R06]
         A_SEL_DIV8:  a_tick = pre_hit(pre_a_ff, DIV8_MASK);  // [R06]
         A_SEL_DIV64: a_tick = pre_hit(pre_a_ff, DIV64_MASK); // [R06]
         A_SEL_CHAIN: a_tick = b_ovf;                  // [R08]
         default:     a_tick = 1'b0;
      endcase
   end

   // second unit clock source; constants never make an edge
   always_comb
   begin
      case (b_sel_ff)
         B_SEL_CPU:  b_tick = 1'b1;                    // [R07]
         B_SEL_SLOW: b_tick = b_slow_tick;             // [R07]
         B_SEL_EXT:  b_tick = ext_edge;                // [R07]
         B_SEL_ZERO: b_tick = 1'b0;                    // [R11]
         B_SEL_ONE:  b_tick = 1'b0;                    // [R11]
         default:    b_tick = 1'b0;
      endcase
   end

   // writing zero clears only in counter mode; other writes ignored
   assign b_clear = TIMER_B_COUNT_WR_I && b_cnt_mode_ff &&
                    TIMER_B_COUNT_I == CNT_ZERO;       // [R04]

   drt_unit u_timer_a
   (
      .clk_i       (CORE_CLK_I),
      .reset_n_i   (RESET_N_I),
      .tick_i      (a_tick),
      .preset_wr_i (TIMER_A_PRESET_WR_I),
      .preset_i    (TIMER_A_PRESET_I),
      .clear_i     (1'b0),
      .count_o     (TIMER_A_COUNT_O),
      .ovf_o       (a_ovf)
   );

   drt_unit u_timer_b
   (
      .clk_i       (CORE_CLK_I),
      .reset_n_i   (RESET_N_I),
      .tick_i      (b_tick),
      .preset_wr_i (TIMER_B_PRESET_WR_I),
      .preset_i    (TIMER_B_PRESET_I),
      .clear_i     (b_clear),
      .count_o     (TIMER_B_COUNT_O),
      .ovf_o       (b_ovf)
   );

   // interrupt requests, one-cycle pulse per enabled overflow
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         a_irq_ff <= 1'b0;
         b_irq_ff <= 1'b0;
      end
      else
      begin
         a_irq_ff <= a_ovf && a_irq_en_ff;             // [R03]
         b_irq_ff <= b_ovf && b_irq_en_ff;             // [R03]
      end
   end

   assign TIMER_A_IRQ_O = a_irq_ff;
   assign TIMER_B_IRQ_O = b_irq_ff;

   // cycles since the last first-unit tick, for the spacing checks only
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         a_gap_ff <= PRE_A_RST;
      else if (a_tick)
         a_gap_ff <= PRE_A_RST;
      else
         a_gap_ff <= a_gap_ff + PRE_A_STEP;
   end

   // set once a tick came under the present select; a control write
   // drops it so a select change never looks like a bad spacing
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         a_run_ff <= 1'b0;
      else
         a_run_ff <= !CTRL_WR_I && (a_run_ff || a_tick);
   end

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   AST_IRQ_A_EN: assert property ( // [R03]
      a_ovf && a_irq_en_ff |=> a_irq_ff)
      else $error("enabled first overflow gave no request");

   AST_IRQ_MASK: assert property ( // [R03]
      !a_irq_en_ff || !a_ovf ##0 !b_irq_en_ff || !b_ovf
      |=> !a_irq_ff && !b_irq_ff)
      else $error("request without enabled overflow");

   AST_B_CONST: assert property ( // [R11]
      (b_sel_ff == B_SEL_ZERO || b_sel_ff == B_SEL_ONE) && !b_clear
      |=> $stable(TIMER_B_COUNT_O))
      else $error("second unit moved on constant source");

   AST_A_DIV8: assert property ( // [R06]
      a_sel_ff == A_SEL_DIV8 && a_run_ff
      |-> a_tick == (a_gap_ff == DIV8_MASK))
      else $error("divide by 8 spacing wrong");

   AST_A_DIV64: assert property ( // [R06]
      a_sel_ff == A_SEL_DIV64 && a_run_ff
      |-> a_tick == (a_gap_ff == DIV64_MASK))
      else $error("divide by 64 spacing wrong");

   AST_CHAIN: assert property ( // [R08]
      a_sel_ff == A_SEL_CHAIN && b_ovf && TIMER_A_COUNT_O != CNT_MAX
      |=> TIMER_A_COUNT_O == CNT_W'($past(TIMER_A_COUNT_O) + 8'h01))
      else $error("chained unit missed carry");

   AST_B_CLEAR: assert property ( // [R04]
      TIMER_B_COUNT_WR_I && b_cnt_mode_ff && TIMER_B_COUNT_I == CNT_ZERO
      |=> TIMER_B_COUNT_O == CNT_ZERO)
      else $error("counter write of zero did not clear");

   // the pin is seen two and three edges back through the synchroniser
   AST_EXT_EDGE: assert property ( // [R07]
      b_sel_ff == B_SEL_EXT && b_tick
      |-> $past(EXTERNAL_COUNT_INPUT_I, 2) &&
          !$past(EXTERNAL_COUNT_INPUT_I, 3))
      else $error("external tick without rising edge");

   COV_A_IRQ: cover property (a_irq_ff);
   COV_B_EXT: cover property (b_sel_ff == B_SEL_EXT && b_ovf);
   COV_CHAIN: cover property (a_sel_ff == A_SEL_CHAIN && a_ovf);
   COV_CLEAR: cover property (b_clear && TIMER_B_COUNT_O != CNT_ZERO);

endmodule

`default_nettype wire

// ==== core/drt_pkg.sv ====
// constants shared by the dual reload timer/counter and its count unit
// assumes a single core clock and an active-low asynchronous reset
//
// What this block does
// R01 - two 8-bit units, second also counts events
// R02 - count up, overflow reloads preset, continue counting
// R03 - overflow raises request only when enabled
// R04 - counter mode: writing zero clears count
// R05 - reading count never disturbs it
// R06 - first unit: cpu, div8, div64, chain
// R07 - second unit: cpu, div65536, external, 0, 1
// R08 - chaining forms one 16-bit timer/counter
// R09 - reset clears counts, presets, enables; first select goes to cpu, second to the constant 0 source
// R10 - preset write takes effect at next overflow
// R11 - constant sources give no edges, count holds
`default_nettype none

package drt_pkg;
   // count width and key values
   localparam int          CNT_W      = 8;
   localparam logic [7:0]  CNT_MAX    = 8'hff;
   localparam logic [7:0]  CNT_ZERO   = 8'h00;
   localparam logic [7:0]  RELOAD_RST = 8'h00;

   // first unit clock select codes
   localparam int          A_SEL_W     = 2;
   localparam logic [1:0]  A_SEL_CPU   = 2'h0;
   localparam logic [1:0]  A_SEL_DIV8  = 2'h1;
   localparam logic [1:0]  A_SEL_DIV64 = 2'h2;
   localparam logic [1:0]  A_SEL_CHAIN = 2'h3;
   localparam logic [1:0]  A_SEL_RST   = 2'h0;

   // second unit clock select codes, unused codes give no edges
   localparam int          B_SEL_W    = 3;
   localparam logic [2:0]  B_SEL_CPU  = 3'h0;
   localparam logic [2:0]  B_SEL_SLOW = 3'h1;
   localparam logic [2:0]  B_SEL_EXT  = 3'h2;
   localparam logic [2:0]  B_SEL_ZERO = 3'h3;
   localparam logic [2:0]  B_SEL_ONE  = 3'h4;
   localparam logic [2:0]  B_SEL_RST  = 3'h3;

   // prescalers
   localparam int          PRE_A_W     = 6;
   localparam logic [5:0]  DIV8_MASK   = 6'h07;
   localparam logic [5:0]  DIV64_MASK  = 6'h3f;
   localparam logic [5:0]  PRE_A_RST   = 6'h00;
   localparam logic [5:0]  PRE_A_STEP  = 6'h01;
   localparam int          PRE_B_W     = 16;
   localparam logic [15:0] PRE_B_RST   = 16'h0000;
   localparam logic [15:0] PRE_B_STEP  = 16'h0001;
   localparam int          B_SLOW_DEF  = 65536;
endpackage

`default_nettype wire

// ==== core/drt_unit.sv ====
// one 8-bit auto-reload up counter with a reload register
// assumes a one-cycle count enable from the same clock domain
`default_nettype none

module drt_unit
   import drt_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             tick_i,
   input  wire logic             preset_wr_i,
   input  wire logic [CNT_W-1:0] preset_i,
   input  wire logic             clear_i,
   output var  logic [CNT_W-1:0] count_o,
   output var  logic             ovf_o
);

   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] reload_ff;
   logic             ovf_ff;

   // reload register, only sampled at overflow so writes never jolt
   // the running count
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         reload_ff <= RELOAD_RST;                      // [R09]
      else if (preset_wr_i)
         reload_ff <= preset_i;                        // [R10]
   end

   // counter; clear wins over a tick in the same cycle
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         count_ff <= CNT_ZERO;                         // [R09]
      else if (clear_i)
         count_ff <= CNT_ZERO;                         // [R04]
      else if (tick_i && count_ff == CNT_MAX)
         count_ff <= reload_ff;                        // [R02]
      else if (tick_i)
         count_ff <= count_ff + 8'h01;                 // [R02]
   end

   // one-cycle overflow pulse
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         ovf_ff <= 1'b0;
      else
         ovf_ff <= tick_i && !clear_i && count_ff == CNT_MAX; // [R02]
   end

   assign count_o = count_ff;                          // [R05]
   assign ovf_o   = ovf_ff;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   AST_RELOAD: assert property ( // [R02]
      tick_i && !clear_i && count_ff == CNT_MAX
      |=> count_ff == $past(reload_ff) && ovf_ff)
      else $error("overflow did not load preset");

   AST_INC: assert property ( // [R02]
      tick_i && !clear_i && count_ff != CNT_MAX
      |=> count_ff == CNT_W'($past(count_ff) + 8'h01) && !ovf_ff)
      else $error("count did not step by one");

   AST_HOLD: assert property ( // [R05]
      !tick_i && !clear_i |=> $stable(count_ff) && !ovf_ff)
      else $error("count moved without a tick");

   AST_CLEAR: assert property ( // [R04]
      clear_i |=> count_ff == CNT_ZERO && !ovf_ff)
      else $error("clear did not zero the count");

   AST_PRESET_LATE: assert property ( // [R10]
      preset_wr_i && !tick_i && !clear_i
      |=> count_ff == $past(count_ff) && reload_ff == $past(preset_i))
      else $error("preset write disturbed count");

   COV_WRAP: cover property (tick_i && count_ff == CNT_MAX);

endmodule

`default_nettype wire

// ==== sim/drt_ext_src.sv ====
// pulse source standing in for whatever drives the external count pin
// assumes the bench clock; the pin only changes on falling edges
`default_nettype none

module drt_ext_src
(
   input  wire logic clk_i,
   input  wire logic run_i,
   output var  logic pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph;

   // idle low outside bursts so a stale level never fakes an edge
   initial
   begin
      pin_o = 1'b0;
      ph = 0;
   end

   // high 3, low 4: slower than the core clock, like a real pin
   always @(negedge clk_i)
   begin
      ph = (ph + 1) % 7;
      pin_o <= run_i && ph < 3;
   end
endmodule

`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench: cycle model of both units against the design
// assumes drt_pkg and the pin source model are compiled first
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   miscompares++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end

module testbench
   import drt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SLOW = 16; // short slow divide keeps the run brief
   logic       clk, rst_n, ext, ext_run, cw, mode, ena, enb;
   logic       apw, bpw, bcw;
   logic [1:0] asel;
   logic [2:0] bsel;
   logic [7:0] apd, bpd, bcd;
   wire logic [7:0] cnt_a, cnt_b;
   wire logic       irq_a, irq_b;
   int ca, cb, ra, rb, pa, pb, sa, sb, cm, ea, eb, oa, ob, ia, ib;
   int ta, tb, clr, miscompares, total_checks;
   int q[$];

   drt_top #(.B_SLOW_DIV(SLOW)) dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
      .EXTERNAL_COUNT_INPUT_I(ext), .CTRL_WR_I(cw), .TIMER_A_CLK_SEL_I(asel),
      .TIMER_B_CLK_SEL_I(bsel), .TIMER_B_COUNTER_MODE_I(mode),
      .TIMER_A_IRQ_EN_I(ena), .TIMER_B_IRQ_EN_I(enb),
      .TIMER_A_PRESET_WR_I(apw), .TIMER_A_PRESET_I(apd),
      .TIMER_B_PRESET_WR_I(bpw), .TIMER_B_PRESET_I(bpd),
      .TIMER_B_COUNT_WR_I(bcw), .TIMER_B_COUNT_I(bcd),
      .TIMER_A_COUNT_O(cnt_a), .TIMER_B_COUNT_O(cnt_b),
      .TIMER_A_IRQ_O(irq_a), .TIMER_B_IRQ_O(irq_b));

   drt_ext_src src (.clk_i(clk), .run_i(ext_run), .pin_o(ext));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // reference model; ticks use the old selects, so new ones act next cycle
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         {ca, cb, ra, rb, pa, pb, sa, cm, ea, eb, oa, ob, ia, ib} = 0;
         sb = 3;
         q = {0, 0, 0, 0, 0};
      end
      else
      begin
         q.push_back(int'(ext));
         void'(q.pop_front());
         ta = sa == 0 || (sa == 1 && pa % 8 == 7) || (sa == 2 && pa == 63)
            || (sa == 3 && ob == 1);
         tb = sb == 0 || (sb == 1 && pb == SLOW - 1)
            || (sb == 2 && q[2] == 1 && q[1] == 0);
         ia = oa & ea;
         ib = ob & eb;
         oa = ta && ca == 255;
         ca = !ta ? ca : ca == 255 ? ra : ca + 1;
         clr = bcw && cm == 1 && bcd == 0;
         ob = tb && cb == 255 && !clr;
         cb = clr ? 0 : !tb ? cb : cb == 255 ? rb : cb + 1;
         if (apw) ra = apd;
         if (bpw) rb = bpd;
         pa = (pa + 1) % 64;
         pb = (pb + 1) % SLOW;
         if (cw)
         begin
            sa = int'(asel);
            sb = int'(bsel);
            cm = int'(mode);
            ea = int'(ena);
            eb = int'(enb);
         end
      end

   // every cycle, reset and the pin path included
   always @(negedge clk)
      begin
         `CHK("count a", ca, cnt_a)
         `CHK("count b", cb, cnt_b)
         `CHK("irq a", ia, irq_a)
         `CHK("irq b", ib, irq_b)
      end

   task automatic wrap_up();
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // control capture strobe, one cycle wide
   task automatic ctl(input logic [1:0] a, input logic [2:0] b,
                      input logic m, input logic xa, input logic xb);
      @(negedge clk);
      {asel, bsel, mode, ena, enb} = {a, b, m, xa, xb};
      cw = 1'b1;
      @(negedge clk);
      cw = 1'b0;
   endtask

   // preset write to timer_a (sel high) or timer_b
   task automatic pre(input logic sel, input logic [7:0] v);
      @(negedge clk);
      {apd, bpd, apw, bpw} = {v, v, sel, !sel};
      @(negedge clk);
      {apw, bpw} = 2'b00;
   endtask

   task automatic bwr(input logic [7:0] v);
      @(negedge clk);
      {bcd, bcw} = {v, 1'b1};
      @(negedge clk);
      bcw = 1'b0;
   endtask

   initial
   begin
      {cw, mode, ena, enb, apw, bpw, bcw, ext_run, rst_n} = '0;
      {asel, bsel, apd, bpd, bcd} = '0;
      {miscompares, total_checks} = 0;
      void'($urandom(31));
      cyc(3);
      rst_n = 1'b1;
      ctl(A_SEL_CPU, B_SEL_ZERO, 1'b1, 1'b1, 1'b1);
      pre(1'b1, 8'hfe);
      cyc(600);
      pre(1'b1, 8'($urandom_range(255))); // lands mid-run
      cyc(600);
      ctl(A_SEL_CPU, B_SEL_ONE, 1'b0, 1'b0, 1'b0); // masked requests
      cyc(600);
      ctl(A_SEL_DIV8, B_SEL_CPU, 1'b0, 1'b1, 1'b1);
      pre(1'b0, 8'hf0);
      cyc(600);
      ctl(A_SEL_DIV64, B_SEL_SLOW, 1'b0, 1'b1, 1'b1);
      pre(1'b1, 8'hfc);
      cyc(2000);
      ctl(A_SEL_CHAIN, B_SEL_CPU, 1'b0, 1'b1, 1'b1);
      cyc(3000);
      // pin bursts, model delays the pin through the synchroniser
      ctl(A_SEL_CHAIN, B_SEL_EXT, 1'b0, 1'b1, 1'b1);
      ext_run = 1'b1;
      cyc(700);
      ext_run = 1'b0;
      cyc(10);
      for (int s = 3; s < 8; s++)
      begin
         ctl(A_SEL_CHAIN, 3'(s), 1'b0, 1'b1, 1'b1);
         cyc(50);
      end
      // zero write clears only in counter mode, nonzero is ignored
      for (int m = 1; m >= 0; m--)
      begin
         ctl(A_SEL_CHAIN, B_SEL_CPU, 1'(m), 1'b1, 1'b1);
         repeat (20)
         begin
            cyc($urandom_range(1, 40));
            bwr($urandom_range(2) == 0 ? 8'($urandom_range(255)) : 8'h00);
         end
      end
      repeat (300)
      begin
         ctl(2'($urandom_range(3)), $urandom_range(1) ? B_SEL_CPU : B_SEL_SLOW,
             1'($urandom_range(1)), 1'($urandom_range(1)), 1'b1);
         pre(1'($urandom_range(1)), 8'($urandom_range(200, 255)));
         bwr(8'h00);
         cyc($urandom_range(1, 30));
      end
      // second reset in mid-run; late in the step so this edge's
      // compare still sees both sides before the reset
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(50);
      wrap_up();
   end

   initial
   begin
      #450000;
      miscompares++;
      wrap_up();
   end
endmodule

`default_nettype wire
